//--- core/pdc_pkg.sv
package pdc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// depth select codes
	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_8BPP  = 2'h1;
	localparam logic [1:0] SEL_16BPP = 2'h2;

	// byte enable patterns
	localparam logic [3:0] BE_ALL  = 4'hF;
	localparam logic [3:0] BE_LANE = 4'h1;
	localparam logic [3:0] BE_LOHW = 4'h3;
	localparam logic [3:0] BE_HIHW = 4'hC;

	// field positions of the unpacked ARGB word
	localparam int RED_LSB   = 16;
	localparam int GREEN_LSB = 8;
	localparam int BLUE_LSB  = 0;
	localparam int ALPHA_LSB = 24;

	// value returned in the alpha byte of an expanded read
	localparam logic [7:0] ALPHA_FILL = 8'h00;
	localparam logic [31:0] REFUSED_DATA = 32'h00000000;
endpackage

//--- core/pdc_port_if.sv
`timescale 1ns/1ps
interface pdc_port_if;
	logic        reqValid;
	logic        reqReady;
	logic        reqWrite;
	logic        reqFromCore;
	logic [31:0] reqAddr;
	logic [31:0] reqWrData;
	logic        rspValid;
	logic [31:0] rspRdData;

	modport device (
		input  reqValid,
		output reqReady,
		input  reqWrite,
		input  reqFromCore,
		input  reqAddr,
		input  reqWrData,
		output rspValid,
		output rspRdData
	);

	modport host (
		output reqValid,
		input  reqReady,
		output reqWrite,
		output reqFromCore,
		output reqAddr,
		output reqWrData,
		input  rspValid,
		input  rspRdData
	);
endinterface

//--- core/pdc_pixel_codec.sv
`timescale 1ns/1ps
module pdc_pixel_codec (
	input  wire logic [1:0]  depthSel,
	input  wire logic [31:0] inAddr,
	input  wire logic [31:0] argbIn,
	input  wire logic [31:0] memWord,
	output logic      [31:0] outAddr,
	output logic      [3:0]  byteEn,
	output logic      [31:0] packedOut,
	output logic      [31:0] argbOut
);
	logic [7:0]  red;
	logic [7:0]  green;
	logic [7:0]  blue;
	logic [7:0]  pix8;
	logic [15:0] pix16;

	always_comb begin
		red   = argbIn[pdc_pkg::RED_LSB +: 8];
		green = argbIn[pdc_pkg::GREEN_LSB +: 8];
		blue  = argbIn[pdc_pkg::BLUE_LSB +: 8];
		pix8  = {red[7:5], green[7:5], blue[7:6]};
		pix16 = {red[7:3], green[7:2], blue[7:3]};
		outAddr   = inAddr;
		byteEn    = pdc_pkg::BE_ALL;
		packedOut = argbIn;
		argbOut   = memWord;
		unique case (depthSel)
			pdc_pkg::SEL_8BPP: begin
				outAddr   = {2'h0, inAddr[31:2]};
				byteEn    = pdc_pkg::BE_LANE << inAddr[1:0];
				packedOut = {4{pix8}};
				pix8    = memWord[{inAddr[1:0], 3'h0} +: 8];
				argbOut = {pdc_pkg::ALPHA_FILL,
					pix8[7:5], pix8[7:5], pix8[6:5],
					pix8[4:2], pix8[4:2], pix8[3:2],
					pix8[1:0], pix8[1:0], pix8[1:0], pix8[1:0]};
			end
			pdc_pkg::SEL_16BPP: begin
				outAddr   = {1'h0, inAddr[31:1]};
				byteEn    = inAddr[0] ? pdc_pkg::BE_HIHW : pdc_pkg::BE_LOHW;
				packedOut = {2{pix16}};
				pix16   = inAddr[0] ? memWord[31:16] : memWord[15:0];
				argbOut = {pdc_pkg::ALPHA_FILL,
					pix16[15:11], pix16[13:11],
					pix16[10:5], pix16[6:5],
					pix16[4:0], pix16[2:0]};
			end
			// code 3 is unused and behaves as no conversion
			default: begin
				outAddr = inAddr;
			end
		endcase
	end
endmodule

//--- core/pdc_converter_end.sv
`timescale 1ns/1ps
module pdc_converter_end (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	pdc_port_if.device       port,
	input  wire logic [1:0]  depthSelect,
	output logic             memValid,
	output logic             memWrite,
	output logic      [31:0] memAddr,
	output logic      [3:0]  memByteEn,
	output logic      [31:0] memWrData,
	input  wire logic        memReady,
	input  wire logic [31:0] memRdData
);
	typedef enum logic [1:0] {IDLE, MEM, RESP} pdc_conv_state_t;

	pdc_conv_state_t state_reg;
	pdc_conv_state_t state_next;
	logic [1:0]      sel_reg;
	logic [1:0]      sel_next;
	logic [31:0]     cpuAddr_reg;
	logic [31:0]     cpuAddr_next;
	logic            memWrite_reg;
	logic            memWrite_next;
	logic [31:0]     memAddr_reg;
	logic [31:0]     memAddr_next;
	logic [3:0]      memByteEn_reg;
	logic [3:0]      memByteEn_next;
	logic [31:0]     memWrData_reg;
	logic [31:0]     memWrData_next;
	logic [31:0]     rdData_reg;
	logic [31:0]     rdData_next;
	logic [1:0]      codecSel;
	logic [31:0]     codecAddr;
	logic [31:0]     xlatAddr;
	logic [3:0]      xlatBe;
	logic [31:0]     packedData;
	logic [31:0]     expandedData;
	logic            takeCore;
	logic            takeForeign;
	logic            memDone;

	// one codec serves both directions: live request while idle, latched one after
	assign codecSel  = (state_reg == IDLE) ? depthSelect : sel_reg;
	assign codecAddr = (state_reg == IDLE) ? port.reqAddr : cpuAddr_reg;

	pdc_pixel_codec i_pdc_pixel_codec (
		.depthSel  (codecSel),
		.inAddr    (codecAddr),
		.argbIn    (port.reqWrData),
		.memWord   (memRdData),
		.outAddr   (xlatAddr),
		.byteEn    (xlatBe),
		.packedOut (packedData),
		.argbOut   (expandedData)
	);

	// taken only while idle, so a new request never disturbs a cycle in flight
	assign takeCore    = (state_reg == IDLE) && port.reqValid && port.reqFromCore;
	assign takeForeign = (state_reg == IDLE) && port.reqValid && !port.reqFromCore;
	assign memDone     = (state_reg == MEM) && memReady;

	assign port.reqReady  = (state_reg == IDLE);
	assign port.rspValid  = (state_reg == RESP);
	assign port.rspRdData = rdData_reg;
	assign memValid       = (state_reg == MEM);
	assign memWrite       = memWrite_reg;
	assign memAddr        = memAddr_reg;
	assign memByteEn      = memByteEn_reg;
	assign memWrData      = memWrData_reg;

	// control: one transfer outstanding at a time
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IDLE: begin
				if (takeCore) begin
					state_next = MEM;
				end else if (takeForeign) begin
					// foreign access completes with no memory cycle
					state_next = RESP;
				end
			end
			MEM: begin
				if (memReady) begin
					state_next = RESP;
				end
			end
			RESP: begin
				state_next = IDLE;
			end
			default: begin
				state_next = IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// select and address kept, so a read expands with the depth it was issued under
	always_comb begin
		sel_next     = sel_reg;
		cpuAddr_next = cpuAddr_reg;
		if (takeCore) begin
			sel_next     = depthSelect;
			cpuAddr_next = port.reqAddr;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_reg     <= pdc_pkg::SEL_NONE;
			cpuAddr_reg <= '0;
		end else begin
			sel_reg     <= sel_next;
			cpuAddr_reg <= cpuAddr_next;
		end
	end

	// transfer direction
	always_comb begin
		memWrite_next = memWrite_reg;
		if (takeCore) begin
			memWrite_next = port.reqWrite;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			memWrite_reg <= 1'h0;
		end else begin
			memWrite_reg <= memWrite_next;
		end
	end

	// translated once at take and held until memory answers
	always_comb begin
		memAddr_next   = memAddr_reg;
		memByteEn_next = memByteEn_reg;
		if (takeCore) begin
			memAddr_next   = xlatAddr;
			memByteEn_next = xlatBe;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			memAddr_reg   <= '0;
			memByteEn_reg <= '0;
		end else begin
			memAddr_reg   <= memAddr_next;
			memByteEn_reg <= memByteEn_next;
		end
	end

	// packed write word
	always_comb begin
		memWrData_next = memWrData_reg;
		if (takeCore) begin
			memWrData_next = packedData;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			memWrData_reg <= '0;
		end else begin
			memWrData_reg <= memWrData_next;
		end
	end

	// refused accesses read as zero, never as stale data
	always_comb begin
		rdData_next = rdData_reg;
		if (takeForeign) begin
			rdData_next = pdc_pkg::REFUSED_DATA;
		end else if (memDone && !memWrite_reg) begin
			rdData_next = expandedData;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_reg <= '0;
		end else begin
			rdData_reg <= rdData_next;
		end
	end
endmodule

//--- core/pdc_core_end.sv
`timescale 1ns/1ps
module pdc_core_end (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	pdc_port_if.host         port,
	input  wire logic        cfgValid,
	input  wire logic [31:0] cfgBase,
	output logic             configured,
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic        cmdWrite,
	input  wire logic [31:0] cmdOffset,
	input  wire logic [31:0] cmdWrData,
	output logic             doneValid,
	output logic      [31:0] doneRdData
);
	typedef enum logic [1:0] {IDLE, REQ, WAIT} pdc_core_state_t;

	pdc_core_state_t state_reg;
	pdc_core_state_t state_next;
	logic            cfg_reg;
	logic            cfg_next;
	logic [31:0]     base_reg;
	logic [31:0]     base_next;
	logic            write_reg;
	logic            write_next;
	logic [31:0]     addr_reg;
	logic [31:0]     addr_next;
	logic [31:0]     wrData_reg;
	logic [31:0]     wrData_next;
	logic            done_reg;
	logic            done_next;
	logic [31:0]     rd_reg;
	logic [31:0]     rd_next;

	// commands wait until a region has been mapped
	assign cmdReady         = cfg_reg && (state_reg == IDLE);
	assign configured       = cfg_reg;
	assign port.reqValid    = (state_reg == REQ);
	assign port.reqWrite    = write_reg;
	assign port.reqFromCore = 1'h1;
	assign port.reqAddr     = addr_reg;
	assign port.reqWrData   = wrData_reg;
	assign doneValid        = done_reg;
	assign doneRdData       = rd_reg;

	always_comb begin
		state_next  = state_reg;
		cfg_next    = cfg_reg;
		base_next   = base_reg;
		write_next  = write_reg;
		addr_next   = addr_reg;
		wrData_next = wrData_reg;
		done_next   = 1'h0;
		rd_next     = rd_reg;
		unique case (state_reg)
			IDLE: begin
				if (cfgValid) begin
					cfg_next  = 1'h1;
					base_next = cfgBase;
				end else if (cmdValid && cfg_reg) begin
					write_next  = cmdWrite;
					addr_next   = base_reg + cmdOffset;
					wrData_next = cmdWrData;
					state_next  = REQ;
				end
			end
			REQ: begin
				if (port.reqReady) begin
					state_next = WAIT;
				end
			end
			WAIT: begin
				if (port.rspValid) begin
					done_next  = 1'b1;
					rd_next    = port.rspRdData;
					state_next = IDLE;
				end
			end
			default: begin
				state_next = IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg  <= IDLE;
			cfg_reg    <= 1'h0;
			base_reg   <= '0;
			write_reg  <= 1'h0;
			addr_reg   <= '0;
			wrData_reg <= '0;
			done_reg   <= 1'h0;
			rd_reg     <= '0;
		end else begin
			state_reg  <= state_next;
			cfg_reg    <= cfg_next;
			base_reg   <= base_next;
			write_reg  <= write_next;
			addr_reg   <= addr_next;
			wrData_reg <= wrData_next;
			done_reg   <= done_next;
			rd_reg     <= rd_next;
		end
	end
endmodule

//--- bench/pdc_asserts.sv
`timescale 1ns/1ps
module pdc_asserts (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        reqValid,
	input wire logic        reqReady,
	input wire logic        reqWrite,
	input wire logic        reqFromCore,
	input wire logic [31:0] reqAddr,
	input wire logic [31:0] reqWrData,
	input wire logic        rspValid,
	input wire logic [31:0] rspRdData
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence takeSeq;
		reqValid && reqReady;
	endsequence
	sequence busySeq;
		!rspValid && !reqReady ##1 !reqReady;
	endsequence
	req_hold_a: assert property (reqValid && !reqReady |=> reqValid && $stable({reqWrite, reqAddr, reqWrData}))
		else $error("request moved while pending");
	rsp_early_a: assert property (takeSeq |=> busySeq)
		else $error("answer too early");
	rsp_bound_a: assert property (takeSeq |-> ##[2:300] rspValid)
		else $error("answer missing");
	rsp_pulse_a: assert property (rspValid |=> !rspValid)
		else $error("answer too long");
	ready_back_a: assert property (rspValid |=> reqReady)
		else $error("port not idle after answer");
	busy_rsp_a: assert property (rspValid |-> !reqReady)
		else $error("idle during answer");
	core_only_a: assert property (reqValid |-> reqFromCore)
		else $error("foreign request");
	rdata_hold_a: assert property (!rspValid |-> $stable(rspRdData))
		else $error("read data moved");
endmodule

//--- bench/tb_pixel_depth_converter_port.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_pixel_depth_converter_port;
	typedef struct {logic w; logic [1:0] s; logic [31:0] a; logic [31:0] d; logic [31:0] m;} pdc_exp_t;
	logic        sys_clk = 0, reset_n = 0, cfgValid = 0, cmdValid = 0, cmdWrite = 0, memReady = 0;
	logic [1:0]  depthSelect = 0;
	logic [31:0] cfgBase = 0, cmdOffset = 0, cmdWrData = 0, memRdData = 0, ea;
	logic [3:0]  eb;
	wire logic   configured, cmdReady, doneValid, memValid, memWrite;
	wire logic [31:0] doneRdData, memAddr, memWrData;
	wire logic [3:0]  memByteEn;
	int          errCount = 0, totalChecks = 0, n;
	pdc_exp_t    q[$], e;
	pdc_port_if portBus();
	pdc_core_end i_pdc_core_end (.sys_clk, .reset_n, .port(portBus), .cfgValid, .cfgBase, .configured,
		.cmdValid, .cmdReady, .cmdWrite, .cmdOffset, .cmdWrData, .doneValid, .doneRdData);
	pdc_converter_end i_pdc_converter_end (.sys_clk, .reset_n, .port(portBus), .depthSelect, .memValid,
		.memWrite, .memAddr, .memByteEn, .memWrData, .memReady, .memRdData);
	pdc_asserts i_pdc_asserts (.sys_clk, .reset_n, .reqValid(portBus.reqValid), .reqReady(portBus.reqReady),
		.reqWrite(portBus.reqWrite), .reqFromCore(portBus.reqFromCore), .reqAddr(portBus.reqAddr),
		.reqWrData(portBus.reqWrData), .rspValid(portBus.rspValid), .rspRdData(portBus.rspRdData));
	always #5 sys_clk = ~sys_clk;
	function automatic logic [35:0] conv(logic [1:0] s, logic [31:0] a);
		case (s)
		2'h1: return {2'h0, a[31:2], 4'h1 << a[1:0]};
		2'h2: return {1'h0, a[31:1], a[0] ? 4'hC : 4'h3};
		default: return {a, 4'hF};
		endcase
	endfunction
	function automatic logic [31:0] pack(logic [1:0] s, logic [31:0] d);
		case (s)
		2'h1: return {4{d[23:21], d[15:13], d[7:6]}};
		2'h2: return {2{d[23:19], d[15:10], d[7:3]}};
		default: return d;
		endcase
	endfunction
	function automatic logic [31:0] expand(logic [1:0] s, logic [1:0] l, logic [31:0] m);
		logic [7:0]  p;
		logic [15:0] h;
		p = m[l*8 +: 8];
		h = l[0] ? m[31:16] : m[15:0];
		case (s)
		2'h1: return {pdc_pkg::ALPHA_FILL, p[7:5], p[7:5], p[6:5], p[4:2], p[4:2], p[3:2], {4{p[1:0]}}};
		2'h2: return {pdc_pkg::ALPHA_FILL, h[15:11], h[13:11], h[10:5], h[6:5], h[4:0], h[2:0]};
		default: return m;
		endcase
	endfunction
	task automatic finalReport();
		if (errCount == 0 && totalChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// memory side stalls at random so the wait states get exercised
	always @(negedge sys_clk) begin
		memReady = 1'($urandom_range(1));
		if (memValid && memReady && q.size() > 0) begin
			e = q[0];
			{ea, eb} = conv(e.s, e.a);
			`CHK("memWrite", e.w, memWrite)
			`CHK("memAddr", ea, memAddr)
			`CHK("memByteEn", eb, memByteEn)
			if (e.w)
				`CHK("memWrData", pack(e.s, e.d), memWrData)
		end
		if (doneValid && q.size() > 0) begin
			e = q.pop_front();
			if (!e.w)
				`CHK("doneRdData", expand(e.s, e.a[1:0], e.m), doneRdData)
		end
	end
	initial begin
		#100000;
		errCount++;
		finalReport();
	end
	initial begin
		void'($urandom(39));
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk) reset_n = 1;
		`CHK("configured", 1'h0, configured)
		`CHK("cmdReady", 1'h0, cmdReady)
		cfgValid = 1;
		cfgBase = $urandom & 32'hFFFFFFFC;
		@(negedge sys_clk) cfgValid = 0;
		`CHK("configured", 1'h1, configured)
		// every select code, both directions, every byte lane
		for (int i = 0; i < 64; i++) begin
			depthSelect = 2'(i);
			cmdWrite = i[2];
			cmdOffset = ($urandom & 32'hFFFFFFFC) | 32'(i[4:3]);
			cmdWrData = $urandom;
			memRdData = $urandom;
			cmdValid = 1;
			q.push_back('{cmdWrite, depthSelect, cfgBase + cmdOffset, cmdWrData, memRdData});
			for (n = 0; !cmdReady && n < 50; n++)
				@(negedge sys_clk);
			@(negedge sys_clk) cmdValid = 0;
			for (n = 0; !doneValid && n < 50; n++)
				@(negedge sys_clk);
			if (n >= 50)
				errCount++;
			@(negedge sys_clk);
		end
		finalReport();
	end
endmodule
